/* File: shared/cio_pkg.sv */
package cio_pkg;

    // Seven-bit bus address that the control port answers to.
    localparam logic [6:0] CIO_I2C_ADDR = 7'h20;

    // Control byte after reset: sensor unpowered and held in reset, all else low.
    localparam logic [7:0] CIO_CTRL_RESET = 8'h00;

    // Bit positions inside the control byte.
    localparam int CIO_BIT_POWER = 0;
    localparam int CIO_BIT_RESET_N = 1;
    localparam int CIO_BIT_LEVEL = 2;
    localparam int CIO_BIT_DRIVE = 3;
    localparam int CIO_BIT_SELECT = 4;
    localparam int CIO_BIT_TRIG_INV = 5;
    localparam int CIO_BIT_TRIG_SRC = 6;
    localparam int CIO_BIT_RESERVED = 7;

    // Number of bits in one byte on the bus, the value at which a byte is complete.
    localparam logic [3:0] CIO_BYTE_BITS = 4'h8;

    // Number of pin inputs that pass through the synchroniser.
    localparam int CIO_SYNC_WIDTH = 6;

    // Indices of the synchronised inputs.
    localparam int CIO_IN_SCL = 0;
    localparam int CIO_IN_SDA = 1;
    localparam int CIO_IN_STROBE = 2;
    localparam int CIO_IN_LINK_TRIG = 3;
    localparam int CIO_IN_CONN_TRIG = 4;
    localparam int CIO_IN_OVERCURRENT = 5;

    // Bus engine states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        CIO_ST_IDLE = 3'b000,
        CIO_ST_ADDR = 3'b001,
        CIO_ST_ADDR_ACK = 3'b011,
        CIO_ST_WDATA = 3'b010,
        CIO_ST_WDATA_ACK = 3'b110,
        CIO_ST_RDATA = 3'b111,
        CIO_ST_RDATA_ACK = 3'b101
    } cio_state_t;

endpackage

/* File: shared/cio_sync_if.sv */
`timescale 1ns/100ps
// Raw pin levels going into the synchroniser and the settled levels coming out.
interface cio_sync_if #(parameter int WIDTH = 6);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] sync;
    modport sync_side (input raw, output sync);
    modport user_side (output raw, input sync);
endinterface

/* File: design/cio_sync.sv */
`timescale 1ns/100ps
module cio_sync
    import cio_pkg::*;
#(
    parameter int WIDTH = 6
)
(
    input wire logic clock,
    input wire logic arst_n,
    cio_sync_if.sync_side pins
);

    // First stage; only the second stage reads it, to contain metastability.
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    // Second stage, the settled copy that the rest of the block uses.
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // Next values of the two stages.
    always_comb
    begin
        meta_next = pins.raw;
        sync_next = meta_reg;
    end

    // Both stages clear to zero under reset.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign pins.sync = sync_reg;

endmodule // cio_sync

/* File: design/cio_expander.sv */
`timescale 1ns/100ps
module cio_expander
    import cio_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic sensor_power_enable,
    output logic sensor_reset_n,
    input wire logic sensor_strobe,
    output logic ser_strobe_gpio,
    input wire logic link_external_trig,
    output logic sensor_trigger,
    input wire logic conn_trigger,
    input wire logic aux_overcurrent_sense,
    output logic user_aux_output_pin,
    output logic user_aux_output_oe_n,
    output logic green_indicator,
    output logic red_overcurrent_indicator
);

    // Pin inputs pass through the synchroniser before any logic reads them.
    cio_sync_if #(.WIDTH(CIO_SYNC_WIDTH)) pins_if ();

    assign pins_if.raw[CIO_IN_SCL] = scl_in;
    assign pins_if.raw[CIO_IN_SDA] = sda_in;
    assign pins_if.raw[CIO_IN_STROBE] = sensor_strobe;
    assign pins_if.raw[CIO_IN_LINK_TRIG] = link_external_trig;
    assign pins_if.raw[CIO_IN_CONN_TRIG] = conn_trigger;
    assign pins_if.raw[CIO_IN_OVERCURRENT] = aux_overcurrent_sense;

    cio_sync #(.WIDTH(CIO_SYNC_WIDTH)) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .pins(pins_if.sync_side)
    );

    // Settled copies of the pins, named for readability.
    logic scl_s;
    logic sda_s;
    logic strobe_s;
    logic link_trig_s;
    logic conn_trig_s;
    logic overcurrent_s;

    assign scl_s = pins_if.sync[CIO_IN_SCL];
    assign sda_s = pins_if.sync[CIO_IN_SDA];
    assign strobe_s = pins_if.sync[CIO_IN_STROBE];
    assign link_trig_s = pins_if.sync[CIO_IN_LINK_TRIG];
    assign conn_trig_s = pins_if.sync[CIO_IN_CONN_TRIG];
    assign overcurrent_s = pins_if.sync[CIO_IN_OVERCURRENT];

    // Bus engine state.
    cio_state_t state_reg;
    cio_state_t state_next;
    // Previous settled bus levels, for edge and condition detection.
    logic scl_prev_reg;
    logic scl_prev_next;
    logic sda_prev_reg;
    logic sda_prev_next;
    // Bits seen in the current byte, zero to eight.
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    // Shift register for address, write data and read data.
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    // Direction latched from the address byte; one means read.
    logic read_reg;
    logic read_next;
    // One while the engine pulls the data line low.
    logic sda_pull_reg;
    logic sda_pull_next;
    // The control byte that software writes.
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;

    // Bus events derived from the settled levels.
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl_rise = scl_s && !scl_prev_reg;
    assign scl_fall = !scl_s && scl_prev_reg;
    assign start_cond = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    assign stop_cond = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

    // Next state of the bus engine. Data is sampled on the clock's rising edge
    // and changed after its falling edge, so the host always sees stable data
    // while the clock is high. A start or stop overrides whatever is in flight.
    always_comb
    begin
        state_next = state_reg;
        scl_prev_next = scl_s;
        sda_prev_next = sda_s;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        read_next = read_reg;
        sda_pull_next = sda_pull_reg;
        ctrl_next = ctrl_reg;
        if (start_cond)
        begin
            // A start, repeated or not, always begins a new address byte.
            state_next = CIO_ST_ADDR;
            bit_cnt_next = '0;
            sda_pull_next = 1'b0;
        end
        else if (stop_cond)
        begin
            // A stop frees the bus and drops any half-received byte.
            state_next = CIO_ST_IDLE;
            sda_pull_next = 1'b0;
        end
        else
        begin
            unique case (state_reg)
                CIO_ST_IDLE:
                begin
                    sda_pull_next = 1'b0;
                end
                CIO_ST_ADDR, CIO_ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        // Sample one bit, most significant first.
                        shift_next = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_reg == CIO_BYTE_BITS)
                    begin
                        bit_cnt_next = '0;
                        if (state_reg == CIO_ST_WDATA)
                        begin
                            // Every data byte replaces the control byte and is acknowledged.
                            ctrl_next = shift_reg;
                            sda_pull_next = 1'b1;
                            state_next = CIO_ST_WDATA_ACK;
                        end
                        else if (shift_reg[7:1] == CIO_I2C_ADDR)
                        begin
                            read_next = shift_reg[0];
                            sda_pull_next = 1'b1;
                            state_next = CIO_ST_ADDR_ACK;
                        end
                        else
                        begin
                            // Another target is addressed; stay off the bus.
                            state_next = CIO_ST_IDLE;
                        end
                    end
                end
                CIO_ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (read_reg)
                        begin
                            // Read back the control byte; its top bit goes out first.
                            shift_next = ctrl_reg;
                            sda_pull_next = !ctrl_reg[7];
                            state_next = CIO_ST_RDATA;
                        end
                        else
                        begin
                            sda_pull_next = 1'b0;
                            state_next = CIO_ST_WDATA;
                        end
                    end
                end
                CIO_ST_WDATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_pull_next = 1'b0;
                        state_next = CIO_ST_WDATA;
                    end
                end
                CIO_ST_RDATA:
                begin
                    if (scl_rise)
                    begin
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (bit_cnt_reg == CIO_BYTE_BITS)
                        begin
                            // Release the line so the host can acknowledge.
                            bit_cnt_next = '0;
                            sda_pull_next = 1'b0;
                            state_next = CIO_ST_RDATA_ACK;
                        end
                        else
                        begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            sda_pull_next = !shift_reg[6];
                        end
                    end
                end
                CIO_ST_RDATA_ACK:
                begin
                    if (scl_rise)
                    begin
                        // Keep the host's answer; a high level is a refusal.
                        shift_next[0] = sda_s;
                    end
                    else if (scl_fall)
                    begin
                        if (shift_reg[0])
                        begin
                            state_next = CIO_ST_IDLE;
                        end
                        else
                        begin
                            shift_next = ctrl_reg;
                            sda_pull_next = !ctrl_reg[7];
                            state_next = CIO_ST_RDATA;
                        end
                    end
                end
                default:
                begin
                    // Unused codes fall back to idle.
                    state_next = CIO_ST_IDLE;
                    sda_pull_next = 1'b0;
                end
            endcase
        end
    end

    // Bus engine and control byte registers. The bus lines idle high, so the
    // previous-level copies reset high to avoid a false start after reset.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= CIO_ST_IDLE;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            bit_cnt_reg <= '0;
            shift_reg <= '0;
            read_reg <= 1'b0;
            sda_pull_reg <= 1'b0;
            ctrl_reg <= CIO_CTRL_RESET;
        end
        else
        begin
            state_reg <= state_next;
            scl_prev_reg <= scl_prev_next;
            sda_prev_reg <= sda_prev_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            read_reg <= read_next;
            sda_pull_reg <= sda_pull_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // The data line is open-drain: low when pulling, otherwise released.
    assign sda_out = 1'b0;
    assign sda_oe_n = !sda_pull_reg;

    // Registered pin outputs and their next values.
    logic power_reg;
    logic power_next;
    logic rst_n_reg;
    logic rst_n_next;
    logic strobe_fwd_reg;
    logic strobe_fwd_next;
    logic trig_reg;
    logic trig_next;
    logic aux_val_reg;
    logic aux_val_next;
    logic aux_oe_n_reg;
    logic aux_oe_n_next;
    logic green_reg;
    logic green_next;
    logic red_reg;
    logic red_next;
    // Level that the user output should present before its drive type applies.
    logic aux_level;
    // Connector trigger after the polarity choice.
    logic conn_trig_pol;

    // Routing of the control bits to the pins. Bit 7 steers nothing, so a
    // host that writes it anyway changes no pin.
    always_comb
    begin
        power_next = ctrl_reg[CIO_BIT_POWER];
        rst_n_next = ctrl_reg[CIO_BIT_RESET_N];
        strobe_fwd_next = strobe_s;
        conn_trig_pol = conn_trig_s ^ ctrl_reg[CIO_BIT_TRIG_INV];
        if (ctrl_reg[CIO_BIT_TRIG_SRC])
        begin
            trig_next = conn_trig_pol;
        end
        else
        begin
            trig_next = link_trig_s;
        end
        if (ctrl_reg[CIO_BIT_SELECT])
        begin
            aux_level = ctrl_reg[CIO_BIT_LEVEL];
            green_next = 1'b0;
        end
        else
        begin
            aux_level = strobe_s;
            green_next = ctrl_reg[CIO_BIT_LEVEL];
        end
        // A low level is always driven; a high one is driven only in push-pull.
        aux_val_next = aux_level;
        aux_oe_n_next = aux_level && !ctrl_reg[CIO_BIT_DRIVE];
        // Overcurrent only matters while the output actively drives high.
        red_next = overcurrent_s && ctrl_reg[CIO_BIT_DRIVE] && aux_level;
    end

    // Pin outputs come from flip-flops so no decode glitch reaches a pin.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            power_reg <= 1'b0;
            rst_n_reg <= 1'b0;
            strobe_fwd_reg <= 1'b0;
            trig_reg <= 1'b0;
            aux_val_reg <= 1'b0;
            aux_oe_n_reg <= 1'b0;
            green_reg <= 1'b0;
            red_reg <= 1'b0;
        end
        else
        begin
            power_reg <= power_next;
            rst_n_reg <= rst_n_next;
            strobe_fwd_reg <= strobe_fwd_next;
            trig_reg <= trig_next;
            aux_val_reg <= aux_val_next;
            aux_oe_n_reg <= aux_oe_n_next;
            green_reg <= green_next;
            red_reg <= red_next;
        end
    end

    assign sensor_power_enable = power_reg;
    assign sensor_reset_n = rst_n_reg;
    assign ser_strobe_gpio = strobe_fwd_reg;
    assign sensor_trigger = trig_reg;
    assign user_aux_output_pin = aux_val_reg;
    assign user_aux_output_oe_n = aux_oe_n_reg;
    assign green_indicator = green_reg;
    assign red_overcurrent_indicator = red_reg;

endmodule // cio_expander

/* File: verif/cio_expander_assertions.sv */
`timescale 1ns/100ps
// Watches the expander pins; the $past checks of three edges wait three edges after reset, the $fell and $stable checks do not.
module cio_expander_checker
    import cio_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic sensor_power_enable,
    input wire logic sensor_reset_n,
    input wire logic sensor_strobe,
    input wire logic ser_strobe_gpio,
    input wire logic link_external_trig,
    input wire logic sensor_trigger,
    input wire logic conn_trigger,
    input wire logic aux_overcurrent_sense,
    input wire logic user_aux_output_pin,
    input wire logic user_aux_output_oe_n,
    input wire logic green_indicator,
    input wire logic red_overcurrent_indicator
);
    logic [1:0] up_cnt_reg; // Edges seen since reset, saturating.
    logic [1:0] up_cnt_next; // Next count.
    logic warm; // High once a three-edge history lies wholly after reset.

    // Without this gate a pin level held during reset would leak into the history.
    always_comb
    begin
        up_cnt_next = (up_cnt_reg == 2'h3) ? up_cnt_reg : up_cnt_reg + 2'h1;
    end

    // Registers the count only.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            up_cnt_reg <= 2'h0;
        else
            up_cnt_reg <= up_cnt_next;
    end

    assign warm = (up_cnt_reg == 2'h3);

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_strobe_route: assert property (warm |-> ser_strobe_gpio == $past(sensor_strobe, 3))
        else $error("strobe not forwarded after three edges");
    a_green_strobe: assert property (warm && green_indicator && !user_aux_output_oe_n
        |-> user_aux_output_pin == $past(sensor_strobe, 3))
        else $error("output does not follow strobe while green lamp lit");
    a_red_drive: assert property (red_overcurrent_indicator
        |-> !user_aux_output_oe_n && user_aux_output_pin)
        else $error("red lamp lit while output not driven high");
    a_red_sense: assert property (warm && red_overcurrent_indicator
        |-> $past(aux_overcurrent_sense, 3))
        else $error("red lamp lit without overcurrent sensed");
    a_sda_open: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl_in)
        else $error("data line pulled while bus clock high");
    a_sda_stable: assert property (scl_in [*4] |-> $stable(sda_oe_n))
        else $error("data line changed during bus clock high");
    // A zero byte keeps the line low from the address answer through all eight data bits,
    // nine bus bits of the host's pace, so the bound leaves room above that.
    a_ack_release: assert property ($fell(sda_oe_n) |-> ##[1:300] $rose(sda_oe_n))
        else $error("data line held low too long");

    c_ack: cover property ($fell(sda_oe_n));
    c_red: cover property (red_overcurrent_indicator);
    c_green: cover property (green_indicator && !user_aux_output_oe_n);
endmodule // cio_expander_checker

bind cio_expander cio_expander_checker cio_expander_checker_i (
    .clock(clock), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .sensor_power_enable(sensor_power_enable),
    .sensor_reset_n(sensor_reset_n), .sensor_strobe(sensor_strobe),
    .ser_strobe_gpio(ser_strobe_gpio), .link_external_trig(link_external_trig),
    .sensor_trigger(sensor_trigger), .conn_trigger(conn_trigger),
    .aux_overcurrent_sense(aux_overcurrent_sense), .user_aux_output_pin(user_aux_output_pin),
    .user_aux_output_oe_n(user_aux_output_oe_n), .green_indicator(green_indicator),
    .red_overcurrent_indicator(red_overcurrent_indicator)
);

/* File: verif/cio_host_model.sv */
`timescale 1ns/100ps
// Bus host; each bus phase is eight clocks, twice the shortest the port can see.
module cio_host_model
    import cio_pkg::*;
(
    input wire logic clock,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    output logic scl_in,
    output logic sda_in
);
    logic scl_reg = 1'b1; // Bus clock, idle high.
    logic sda_host_reg = 1'b1; // Host side of the data line, 1 is released.

    // Wired-and with a pull-up: a released line reads high, never a stale value.
    assign sda_in = sda_host_reg & (sda_oe_n | sda_out);
    assign scl_in = scl_reg;

    // Waits one bus phase.
    task automatic half();
        repeat (8) @(posedge clock);
    endtask

    // Also serves as a repeated start, since data is raised before the clock.
    task automatic start_cond();
        half();
        sda_host_reg <= 1'b1;
        half();
        scl_reg <= 1'b1;
        half();
        sda_host_reg <= 1'b0;
        half();
        scl_reg <= 1'b0;
    endtask

    task automatic stop_cond();
        half();
        sda_host_reg <= 1'b0;
        half();
        scl_reg <= 1'b1;
        half();
        sda_host_reg <= 1'b1;
        half();
    endtask

    // Puts one bit out and samples the line at the end of the high phase, as the clock falls.
    task automatic bit_io(input logic b, output logic s);
        half();
        sda_host_reg <= b;
        half();
        scl_reg <= 1'b1;
        half();
        s = sda_in;
        scl_reg <= 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, nack);
    endtask

    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(nack, s);
    endtask
endmodule // cio_host_model

/* File: verif/test_camera_io_control_expander.sv */
`timescale 1ns/100ps
module test_camera_io_control_expander;
    import cio_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic scl_in, sda_in, sda_out, sda_oe_n;
    logic sensor_strobe = 1'b0;
    logic link_external_trig = 1'b0;
    logic conn_trigger = 1'b0;
    logic aux_overcurrent_sense = 1'b0;
    logic sensor_power_enable, sensor_reset_n, ser_strobe_gpio, sensor_trigger;
    logic user_aux_output_pin, user_aux_output_oe_n, green_indicator, red_overcurrent_indicator;
    int n_fail = 0;
    int checks_done = 0;
    // Bit 7 stays 0 in every value written; the last entry is the one kept at the end.
    logic [7:0] ctrl_tab [12] = '{8'h03, 8'h04, 8'h14, 8'h1C, 8'h18, 8'h08, 8'h0C,
        8'h60, 8'h20, 8'h40, 8'h00, 8'h7F};

    always #25 clock = ~clock;

    cio_expander cio_expander_i (.clock(clock), .arst_n(arst_n), .scl_in(scl_in),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .sensor_power_enable(sensor_power_enable), .sensor_reset_n(sensor_reset_n),
        .sensor_strobe(sensor_strobe), .ser_strobe_gpio(ser_strobe_gpio),
        .link_external_trig(link_external_trig), .sensor_trigger(sensor_trigger),
        .conn_trigger(conn_trigger), .aux_overcurrent_sense(aux_overcurrent_sense),
        .user_aux_output_pin(user_aux_output_pin), .user_aux_output_oe_n(user_aux_output_oe_n),
        .green_indicator(green_indicator), .red_overcurrent_indicator(red_overcurrent_indicator));

    cio_host_model cio_host_model_i (.clock(clock), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .scl_in(scl_in), .sda_in(sda_in));

    task automatic check(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        for (int i = 0; i < 8; i++)
            check(what, exp[i], got[i]);
    endtask

    task automatic results();
        $display("Counts: %0d checks, %0d failures", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // A refused address must leave the data byte unsent.
    task automatic ctrl_write(input logic [6:0] addr, input logic [7:0] data, input logic exp_nack);
        logic nack;
        cio_host_model_i.start_cond();
        cio_host_model_i.send_byte({addr, 1'b0}, nack);
        check("address answer", exp_nack, nack);
        if (nack === 1'b0)
        begin
            cio_host_model_i.send_byte(data, nack);
            check("data answer", 1'b0, nack);
        end
        cio_host_model_i.stop_cond();
    endtask

    // Addresses for writing, turns round with a repeated start and reads two bytes,
    // acknowledging the first; the empty write must leave the control byte alone.
    task automatic ctrl_read(input string what, input logic [7:0] exp);
        logic nack;
        logic [7:0] d;
        cio_host_model_i.start_cond();
        cio_host_model_i.send_byte({CIO_I2C_ADDR, 1'b0}, nack);
        check("turnaround address answer", 1'b0, nack);
        cio_host_model_i.start_cond();
        cio_host_model_i.send_byte({CIO_I2C_ADDR, 1'b1}, nack);
        check("read address answer", 1'b0, nack);
        cio_host_model_i.recv_byte(1'b0, d);
        check_byte(what, exp, d);
        cio_host_model_i.recv_byte(1'b1, d);
        check_byte(what, exp, d);
        cio_host_model_i.stop_cond();
    endtask

    // Walks all sixteen input combinations under one control byte.
    task automatic pins_check(input logic [7:0] c);
        logic l;
        logic e_oe;
        for (int k = 0; k < 16; k++)
        begin
            @(posedge clock);
            {sensor_strobe, link_external_trig, conn_trigger, aux_overcurrent_sense} <= k[3:0];
            repeat (5) @(posedge clock);
            @(negedge clock);
            l = c[4] ? c[2] : sensor_strobe;
            e_oe = l & ~c[3];
            check("power", c[0], sensor_power_enable);
            check("sensor reset", c[1], sensor_reset_n);
            check("strobe out", sensor_strobe, ser_strobe_gpio);
            check("trigger", c[6] ? conn_trigger ^ c[5] : link_external_trig, sensor_trigger);
            check("green", ~c[4] & c[2], green_indicator);
            check("output enable", e_oe, user_aux_output_oe_n);
            if (e_oe === 1'b0)
                check("output level", l, user_aux_output_pin);
            check("red", aux_overcurrent_sense & c[3] & l, red_overcurrent_indicator);
        end
    endtask

    initial
    begin
        repeat (60000) @(posedge clock);
        n_fail++;
        results();
    end

    initial
    begin
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (8) @(posedge clock);
        @(negedge clock);
        check("data released", 1'b1, sda_oe_n);
        ctrl_read("reset value", CIO_CTRL_RESET);
        pins_check(CIO_CTRL_RESET);
        $display("test reset done");
        foreach (ctrl_tab[i])
        begin
            ctrl_write(CIO_I2C_ADDR, ctrl_tab[i], 1'b0);
            ctrl_read("readback", ctrl_tab[i]);
            pins_check(ctrl_tab[i]);
            $display("test control %h done", ctrl_tab[i]);
        end
        ctrl_write(CIO_I2C_ADDR + 7'h01, 8'h00, 1'b1);
        ctrl_read("foreign address", 8'h7F);
        $display("test foreign address done");
        // A reset in mid-run must bring the control byte back to its reset value.
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        ctrl_read("second reset value", CIO_CTRL_RESET);
        $display("test second reset done");
        results();
    end
endmodule // test_camera_io_control_expander
